// ===== eepc_ctrl.sv
// Purpose: EEPROM program/erase control with APB register slave
// Assumes: 40 MHz ref_clk, asynchronous active-low reset, stop request is a pin
// Notes: Software times every pulse; array window at 0x400 holds 256 words
`timescale 1ns/10ps
module eepc_ctrl
	import eepc_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic arst_n,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Power-mode pins
	input wire logic stop_req,
	input wire logic rc_osc_clk,
	// Analog controls
	output logic charge_pump_on,
	output logic array_power_on,
	output logic rc_osc_enable,
	output logic clock_from_rc
);
`include "eepc_defs.svh"

	eepc_arr_if arr();

	eepc_array u_array (
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.arr(arr)
	);

	////////////////////////////////////////////////////////////////
	// Control register fields
	logic charge_pump_enable;
	logic erase_select_high;
	logic erase_select_low;
	logic program_latch_enable;
	logic rc_clock_select;
	logic program_power_enable;
	logic [7:0] eeprom_program_control;
	logic [7:0] lat_addr;
	logic [7:0] lat_data;
	logic write_latched;
	logic [2:0] stop_sync;
	logic stop_now;
	logic [2:0] rc_sync;
	logic rc_alive;
	logic [1:0] arm_cnt;
	eepc_state_t state;
	eepc_state_t next_state;

	logic acc;
	logic wr;
	logic rd;
	logic ctrl_hit;
	logic arr_hit;
	logic known;

	assign acc = psel && penable;
	assign wr = acc && pwrite;
	assign rd = acc && !pwrite;
	assign ctrl_hit = paddr == `EEPC_CTRL_ADDR;
	assign arr_hit = paddr >= `EEPC_ARRAY_BASE && paddr <= `EEPC_ARRAY_LAST && paddr[1:0] == 2'b00;
	assign known = ctrl_hit || arr_hit || paddr == `EEPC_DATA_ADDR || paddr == `EEPC_STAT_ADDR;

	assign eeprom_program_control = {2'b00, charge_pump_enable, rc_clock_select, erase_select_high,
		erase_select_low, program_latch_enable, program_power_enable};

	////////////////////////////////////////////////////////////////
	// Pin synchronisers: stop needs second and third stages to agree; RC is alive when they differ
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			stop_sync <= 3'b000;
			stop_now <= 1'b0;
			rc_sync <= 3'b000;
			rc_alive <= 1'b0;
		end else begin
			stop_sync <= {stop_sync[1:0], stop_req};
			rc_sync <= {rc_sync[1:0], rc_osc_clk};
			if (stop_sync[1] == stop_sync[2])
				stop_now <= stop_sync[2];
			if (rc_sync[1] != rc_sync[2])
				rc_alive <= 1'b1;
			else if (!rc_clock_select)
				rc_alive <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////
	// Control register
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			charge_pump_enable <= 1'b0;
			erase_select_high <= 1'b0;
			erase_select_low <= 1'b0;
			program_latch_enable <= 1'b0;
			rc_clock_select <= 1'b0;
			program_power_enable <= 1'b0;
		end else begin
			if (wr && ctrl_hit) begin
				charge_pump_enable <= pwdata[`EEPC_BIT_CHARGE_PUMP_ENABLE];
				erase_select_high <= pwdata[`EEPC_BIT_ER1];
				erase_select_low <= pwdata[`EEPC_BIT_ER0];
				program_latch_enable <= pwdata[`EEPC_BIT_LAT];
				rc_clock_select <= pwdata[`EEPC_BIT_RC];
				// Latch must already be 1 before this write
				if (program_latch_enable)
					program_power_enable <= pwdata[`EEPC_BIT_PGM];
			end
			if (stop_now)
				rc_clock_select <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////
	// Address and data latches
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			lat_addr <= 8'h00;
			lat_data <= 8'h00;
			write_latched <= 1'b0;
		end else if (!program_latch_enable) begin
			write_latched <= 1'b0;
		end else if (wr && arr_hit && !program_power_enable) begin
			lat_addr <= paddr[9:2];
			lat_data <= pwdata[7:0];
			write_latched <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////
	// Sequencer: array power only while power enable is set
	always_comb begin
		next_state = state;
		case (state)
			eepc_st_idle: begin
				if (write_latched)
					next_state = eepc_st_latched;
			end
			eepc_st_latched: begin
				if (!write_latched)
					next_state = eepc_st_idle;
				else if (program_power_enable && arm_cnt == 2'(`EEPC_PUMP_ARM_CYC))
					next_state = eepc_st_power;
			end
			eepc_st_power: begin
				if (!program_power_enable)
					next_state = write_latched ? eepc_st_latched : eepc_st_idle;
			end
			default: next_state = eepc_st_idle;
		endcase
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n)
			state <= eepc_st_idle;
		else
			state <= next_state;
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n)
			arm_cnt <= 2'b00;
		else if (!program_power_enable || state != eepc_st_latched)
			arm_cnt <= 2'b00;
		else if (arm_cnt != 2'(`EEPC_PUMP_ARM_CYC))
			arm_cnt <= arm_cnt + 2'b01;
	end

	// Array is committed when power is removed; an abort by reset never commits
	assign arr.op_pulse = state == eepc_st_power && !program_power_enable;
	assign arr.op_mode = {erase_select_high, erase_select_low};
	assign arr.op_addr = lat_addr;
	assign arr.op_data = lat_data;
	assign arr.rd_addr = paddr[9:2];

	////////////////////////////////////////////////////////////////
	// Analog outputs, registered
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			charge_pump_on <= 1'b0;
			array_power_on <= 1'b0;
			rc_osc_enable <= 1'b0;
			clock_from_rc <= 1'b0;
		end else begin
			charge_pump_on <= charge_pump_enable || program_power_enable;
			array_power_on <= next_state == eepc_st_power;
			rc_osc_enable <= rc_clock_select && !stop_now;
			clock_from_rc <= rc_clock_select && rc_alive;
		end
	end

	////////////////////////////////////////////////////////////////
	// APB answer: no wait state, zero-wait on the access phase edge
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && (!known || (arr_hit && !pwrite && write_latched && program_latch_enable));
			prdata <= 32'h0000_0000;
			if (psel && !penable && !pwrite) begin
				if (ctrl_hit)
					prdata <= {24'h00_0000, eeprom_program_control};
				else if (paddr == `EEPC_DATA_ADDR)
					prdata <= {24'h00_0000, lat_data};
				else if (paddr == `EEPC_STAT_ADDR)
					prdata <= {22'h00_0000, state, lat_addr};
				else if (arr_hit && !(program_latch_enable && write_latched))
					prdata <= {24'h00_0000, arr.rd_data};
			end
		end
	end
endmodule

// ===== eepc_defs.svh
// Purpose: Offsets, field positions, reset values and timing counts of the EEPROM program/erase control
// Assumes: APB, 32-bit data, 40 MHz ref_clk
// Notes: Included by the design modules and by the testbench
`ifndef EEPC_DEFS_SVH
`define EEPC_DEFS_SVH

// Register byte addresses (APB)
`define EEPC_CTRL_ADDR 12'h000
`define EEPC_DATA_ADDR 12'h004
`define EEPC_STAT_ADDR 12'h008
`define EEPC_ARRAY_BASE 12'h400
`define EEPC_ARRAY_LAST 12'h7FC

// Control field positions
`define EEPC_BIT_PGM 0
`define EEPC_BIT_LAT 1
`define EEPC_BIT_ER0 2
`define EEPC_BIT_ER1 3
`define EEPC_BIT_RC 4
`define EEPC_BIT_CHARGE_PUMP_ENABLE 5
`define EEPC_CTRL_RESET 8'h00
`define EEPC_ERASED 8'hFF

// Power-enable arming delay, time in ns and cycles
`define EEPC_PUMP_ARM_NS 50
`define EEPC_CLK_NS 25
`define EEPC_PUMP_ARM_CYC ((`EEPC_PUMP_ARM_NS + `EEPC_CLK_NS - 1) / `EEPC_CLK_NS)

`endif

// ===== eepc_pkg.sv
// Purpose: Types shared by the EEPROM control block
// Assumes: Encodings are defined here; eepc_defs.svh is not included
// Notes: None
package eepc_pkg;
	typedef enum logic [1:0] {
		eepc_erase_none = 2'b00,
		eepc_erase_byte = 2'b01,
		eepc_erase_block = 2'b10,
		eepc_erase_bulk = 2'b11
	} eepc_erase_t;

	typedef enum logic [1:0] {
		eepc_st_idle = 2'b00,
		eepc_st_latched = 2'b01,
		eepc_st_power = 2'b10
	} eepc_state_t;
endpackage

// ===== eepc_arr_if.sv
// Purpose: Carries array operation requests between control and storage
// Assumes: Single clock
// Notes: Pulse strobes, one cycle
`timescale 1ns/10ps
interface eepc_arr_if;
	logic [7:0] rd_addr;
	logic [7:0] rd_data;
	logic op_pulse;
	logic [1:0] op_mode;
	logic [7:0] op_addr;
	logic [7:0] op_data;
	modport ctrl (output rd_addr, output op_pulse, output op_mode, output op_addr, output op_data, input rd_data);
	modport store (input rd_addr, input op_pulse, input op_mode, input op_addr, input op_data, output rd_data);
endinterface

// ===== eepc_array.sv
// Purpose: 256-byte nonvolatile array model with byte, block and bulk erase
// Assumes: One operation per pulse
// Notes: Contents undefined after an aborted operation; modelled as unchanged
`timescale 1ns/10ps
module eepc_array
	import eepc_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic arst_n,
	// Array port
	eepc_arr_if.store arr
);
`include "eepc_defs.svh"

	logic [7:0] mem [0:255];

	assign arr.rd_data = mem[arr.rd_addr];

	////////////////////////////////////////////////////////////////
	genvar gi;
	generate
		for (gi = 0; gi < 256; gi++) begin : g_cell
			always_ff @(posedge ref_clk) begin
				if (arr.op_pulse) begin
					case (arr.op_mode)
						eepc_erase_none: begin
							if (arr.op_addr == 8'(gi))
								mem[gi] <= mem[gi] & arr.op_data;
						end
						eepc_erase_byte: begin
							if (arr.op_addr == 8'(gi))
								mem[gi] <= `EEPC_ERASED;
						end
						eepc_erase_block: begin
							if (arr.op_addr[7:6] == 2'(gi >> 6))
								mem[gi] <= `EEPC_ERASED;
						end
						default: begin
							mem[gi] <= `EEPC_ERASED;
						end
					endcase
				end
			end
		end
	endgenerate
endmodule

// ===== eepc_ctrl_assertions.sv
// Purpose: Port checks of the EEPROM control block
// Assumes: One clock, async active-low reset
// Notes: Bound to eepc_ctrl
`timescale 1ns/10ps
module eepc_chk (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic arst_n,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Controls
	input wire logic stop_req,
	input wire logic charge_pump_on,
	input wire logic array_power_on,
	input wire logic rc_osc_enable
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	logic ctrl_wr;
	assign ctrl_wr = psel && penable && pready && pwrite && paddr == 12'h000;
	////////////////////////////////////////
	power_pump_a: assert property (array_power_on |-> charge_pump_on) else $error("power without pump");
	pump_set_a: assert property (ctrl_wr && pwdata[5] |-> ##[1:2] charge_pump_on) else $error("pump off");
	pump_clr_a: assert property (ctrl_wr && pwdata[7:0] == 8'h00 |-> ##[1:3] !charge_pump_on) else $error("pump on");
	power_off_a: assert property (ctrl_wr && pwdata[1:0] == 2'h2 |-> ##[1:2] !array_power_on) else $error("power on");
	reset_clear_a: assert property ($rose(arst_n) |-> !charge_pump_on && !array_power_on) else $error("not cleared");
	stop_rc_a: assert property (stop_req [*6] |-> !rc_osc_enable) else $error("rc kept in stop");
	apb_answer_a: assert property (psel && !penable |=> pready ##1 !pready) else $error("bad answer");
	blocked_a: assert property (pready && pslverr |-> prdata == 32'h0000_0000) else $error("data leaked");
	cover property ($rose(array_power_on));
	cover property (pready && pslverr);
	cover property ($fell(rc_osc_enable));
endmodule
bind eepc_ctrl eepc_chk i_chk (.ref_clk(ref_clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .stop_req(stop_req),
	.charge_pump_on(charge_pump_on), .array_power_on(array_power_on), .rc_osc_enable(rc_osc_enable));

// ===== tb.sv
// Purpose: Self-checking bench of the EEPROM control block
// Assumes: Software times each pulse, so short pulses suffice
// Notes: Aborted byte is not checked, its contents are undefined
`timescale 1ns/10ps
`include "eepc_defs.svh"
module tb;
	logic ref_clk = 1'h0, arst_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, stop_req = 1'h0, rc_osc_clk = 1'h0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000, prdata, rdat;
	logic pready, pslverr, rerr, charge_pump_on, array_power_on, rc_osc_enable, clock_from_rc;
	int errors = 0, n_tests = 0;
	always #12.5 ref_clk = ~ref_clk;
	always @(posedge ref_clk) rc_osc_clk <= ~rc_osc_clk;
	eepc_ctrl i_dut (.ref_clk(ref_clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .stop_req(stop_req),
		.rc_osc_clk(rc_osc_clk), .charge_pump_on(charge_pump_on), .array_power_on(array_power_on),
		.rc_osc_enable(rc_osc_enable), .clock_from_rc(clock_from_rc));
	////////////////////////////////////////
	task complete_run;
		$display("Checks %0d, mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// Sampling pready just after the edge sees the access-cycle value
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'h1;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pready !== 1'h1 && n < 20);
		if (n >= 20) begin
			errors++;
			complete_run();
		end
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge ref_clk);
	endtask
	task rd(input logic [11:0] a, input logic [31:0] e, input logic err);
		apb(1'h0, a, 32'h0000_0000);
		chk(rdat, e);
		chk(rerr, err);
	endtask
	function logic [11:0] ba(input logic [7:0] n);
		return `EEPC_ARRAY_BASE + {n, 2'h0};
	endfunction
	task op(input logic [7:0] c, input logic [7:0] n, input logic [7:0] d);
		apb(1'h1, `EEPC_CTRL_ADDR, c);
		apb(1'h1, ba(n), d);
		rd(ba(n), 32'h0000_0000, 1'h1);
		rd(`EEPC_DATA_ADDR, {24'h00_0000, d}, 1'h0);
		// Status word: sequencer in its latched state, target index below
		rd(`EEPC_STAT_ADDR, {22'h00_0000, 2'h1, n}, 1'h0);
		apb(1'h1, `EEPC_CTRL_ADDR, c | 8'h01);
		repeat (4) @(posedge ref_clk);
		chk(array_power_on, 1'h1);
		chk(charge_pump_on, 1'h1);
		apb(1'h1, `EEPC_CTRL_ADDR, c);
		apb(1'h1, `EEPC_CTRL_ADDR, 32'h0000_0000);
	endtask
	////////////////////////////////////////
	task test_control;
		rd(`EEPC_CTRL_ADDR, 32'h0000_0000, 1'h0);
		for (int i = 0; i < 4; i++) begin
			apb(1'h1, `EEPC_CTRL_ADDR, 8'h22 | (i << 2));
			rd(`EEPC_CTRL_ADDR, 8'h22 | (i << 2), 1'h0);
		end
		chk(charge_pump_on, 1'h1);
		apb(1'h1, `EEPC_CTRL_ADDR, 32'h0000_0000);
		apb(1'h1, `EEPC_CTRL_ADDR, 32'h0000_0021);
		rd(`EEPC_CTRL_ADDR, 32'h0000_0020, 1'h0);
		chk(array_power_on, 1'h0);
		apb(1'h1, `EEPC_CTRL_ADDR, 32'h0000_0000);
		repeat (2) @(posedge ref_clk);
		chk(charge_pump_on, 1'h0);
		$display("Control tests done");
	endtask
	task test_array;
		op(8'h2E, 8'h00, 8'h00);
		rd(ba(8'hC8), 32'h0000_00FF, 1'h0);
		op(8'h22, 8'h05, 8'hA5);
		op(8'h22, 8'h06, 8'h3C);
		rd(ba(8'h05), 32'h0000_00A5, 1'h0);
		op(8'h22, 8'h05, 8'h5A);
		rd(ba(8'h05), 32'h0000_0000, 1'h0);
		op(8'h26, 8'h05, 8'h00);
		rd(ba(8'h05), 32'h0000_00FF, 1'h0);
		rd(ba(8'h06), 32'h0000_003C, 1'h0);
		op(8'h22, 8'h40, 8'h00);
		op(8'h22, 8'h3F, 8'h00);
		op(8'h2A, 8'h7F, 8'h00);
		rd(ba(8'h40), 32'h0000_00FF, 1'h0);
		rd(ba(8'h3F), 32'h0000_0000, 1'h0);
		rd(12'h00C, 32'h0000_0000, 1'h1);
		$display("Array tests done");
	endtask
	task test_rc;
		apb(1'h1, `EEPC_CTRL_ADDR, 32'h0000_0010);
		repeat (8) @(posedge ref_clk);
		chk(rc_osc_enable, 1'h1);
		chk(clock_from_rc, 1'h1);
		stop_req <= 1'h1;
		repeat (8) @(posedge ref_clk);
		chk(rc_osc_enable, 1'h0);
		rd(`EEPC_CTRL_ADDR, 32'h0000_0000, 1'h0);
		stop_req <= 1'h0;
		// Let the stop level drain through the synchroniser before reselecting
		repeat (6) @(posedge ref_clk);
		apb(1'h1, `EEPC_CTRL_ADDR, 32'h0000_0010);
		repeat (4) @(posedge ref_clk);
		chk(rc_osc_enable, 1'h1);
		apb(1'h1, `EEPC_CTRL_ADDR, 32'h0000_0000);
		repeat (2) @(posedge ref_clk);
		chk(rc_osc_enable, 1'h0);
		chk(clock_from_rc, 1'h0);
		$display("Stop test done");
	endtask
	task test_abort;
		apb(1'h1, `EEPC_CTRL_ADDR, 32'h0000_0022);
		apb(1'h1, ba(8'h09), 32'h0000_0000);
		apb(1'h1, `EEPC_CTRL_ADDR, 32'h0000_0023);
		repeat (4) @(posedge ref_clk);
		chk(array_power_on, 1'h1);
		arst_n <= 1'h0;
		repeat (2) @(posedge ref_clk);
		chk(array_power_on, 1'h0);
		chk(charge_pump_on, 1'h0);
		arst_n <= 1'h1;
		@(posedge ref_clk);
		rd(`EEPC_CTRL_ADDR, 32'h0000_0000, 1'h0);
		rd(`EEPC_STAT_ADDR, 32'h0000_0000, 1'h0);
		$display("Abort test done");
	endtask
	////////////////////////////////////////
	initial begin
		repeat (5) @(posedge ref_clk);
		arst_n <= 1'h1;
		@(posedge ref_clk);
		test_control();
		test_array();
		test_rc();
		test_abort();
		complete_run();
	end
endmodule
